// [verilog/rcp_pkg.sv]
// Package: constants, register map and carrier types of the rail control pin block
package rcp_pkg;

  localparam int unsigned NUM_CTL  = 6;
  localparam int unsigned NUM_REG  = 8;
  localparam int unsigned NUM_GPO  = 4;
  localparam int unsigned NUM_IRQ  = 5;

  // Register byte offsets
  localparam logic [5:0] OFS_EN_GROUP0  = 6'h00;
  localparam logic [5:0] OFS_EN_GROUP5  = 6'h14;
  localparam logic [5:0] OFS_SLEEP_CFG  = 6'h18;
  localparam logic [5:0] OFS_GPO_CFG    = 6'h1C;
  localparam logic [5:0] OFS_GPO_MASK0  = 6'h20;
  localparam logic [5:0] OFS_GPO_MASK3  = 6'h2C;
  localparam logic [5:0] OFS_STATUS     = 6'h30;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h34;
  localparam logic [5:0] OFS_IRQ_CLEAR  = 6'h38;
  localparam logic [5:0] OFS_IRQ_ENABLE = 6'h3C;

  // Sleep configuration fields
  localparam int unsigned SLP_MODE_A_BIT = 0;
  localparam int unsigned SLP_MODE_B_BIT = 1;
  localparam int unsigned SLP_GRP_A_LSB  = 8;
  localparam int unsigned SLP_GRP_B_LSB  = 16;

  // Output configuration: four bits per output
  localparam int unsigned GPO_CFG_W      = 4;
  localparam int unsigned GPO_PUSHPULL_B = 0;
  localparam int unsigned GPO_SRC_USER_B = 1;
  localparam int unsigned GPO_USER_VAL_B = 2;

  // Status register fields
  localparam int unsigned ST_EN_LSB    = 0;
  localparam int unsigned ST_SLEEP_LSB = 8;
  localparam int unsigned ST_PG_LSB    = 16;
  localparam int unsigned ST_PROG_BIT  = 24;

  // Interrupt event bits
  localparam int unsigned IRQ_EN_CHANGE = 0;
  localparam int unsigned IRQ_SLP_ENTER = 1;
  localparam int unsigned IRQ_SLP_EXIT  = 2;
  localparam int unsigned IRQ_PROG      = 3;
  localparam int unsigned IRQ_PG_FAULT  = 4;

  // Reset values
  localparam logic [7:0]  RST_GROUP     = 8'h00;
  localparam logic [31:0] RST_SLEEP_CFG = 32'h0000_0000;
  localparam logic [3:0]  RST_GPO_CFG   = 4'h0;
  localparam logic [4:0]  RST_IRQ       = 5'h00;

  // Programming level must stay high this long to count as stable
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned PROG_STAB_US = 100;
  localparam int unsigned PROG_STAB_CY = (PROG_STAB_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PROG_CNT_W   = 12;

  typedef struct packed {
    logic user_val;
    logic src_user;
    logic pushpull;
  } rcp_gpo_cfg_t;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [5:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } rcp_bus_req_t;

endpackage

// [verilog/rcp_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module rcp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// [verilog/rcp_top.sv]
// Rail control pins, general outputs, interrupt pin and programming detect
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module rcp_top
  import rcp_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic [5:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [3:0]          avs_byteenable_i,
  input  wire logic [31:0]         avs_writedata_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic [NUM_CTL-1:0]  rail_enable_in_i,
  input  wire logic                prog_level_i,
  input  wire logic [NUM_REG-1:0]  regulator_pgood_i,
  output logic      [NUM_REG-1:0]  regulator_enable_o,
  output logic      [NUM_REG-1:0]  regulator_sleep_o,
  output logic                     prog_state_o,
  output logic      [NUM_GPO-1:0]  gen_out_o,
  output logic      [NUM_GPO-1:0]  gen_out_oe_o,
  output logic                     irq_out_n_o,
  output logic                     irq_out_n_oe_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // An empty mask yields true: nothing selected, nothing failing
  function automatic logic all_good(input logic [NUM_REG-1:0] pg,
                                    input logic [NUM_REG-1:0] mask);
    return &(pg | ~mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [NUM_CTL-1:0] ctl_s;
  logic [NUM_REG-1:0] pg_s;
  logic               prog_s;

  rcp_sync #(
    .W (NUM_CTL + NUM_REG + 1)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({prog_level_i, regulator_pgood_i, rail_enable_in_i}),
    .q_o    ({prog_s, pg_s, ctl_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle per access

  rcp_bus_req_t req;
  logic         accept;
  logic         wr_hit;

  assign req.read       = avs_read_i;
  assign req.write      = avs_write_i;
  assign req.address    = avs_address_i;
  assign req.byteenable = avs_byteenable_i;
  assign req.writedata  = avs_writedata_i;

  // Request completes at the edge where waitrequest is seen low
  assign accept = (req.read | req.write) & ~avs_waitrequest_o;
  assign wr_hit = accept & req.write;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((req.read | req.write) & avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [NUM_REG-1:0] en_group  [NUM_CTL];
  logic [NUM_REG-1:0] gpo_mask  [NUM_GPO];
  logic [31:0]        sleep_cfg;
  rcp_gpo_cfg_t       gpo_cfg   [NUM_GPO];
  logic [NUM_IRQ-1:0] irq_enable;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_CTL; i++) begin
        en_group[i] <= RST_GROUP;
      end
      for (int i = 0; i < NUM_GPO; i++) begin
        gpo_mask[i] <= RST_GROUP;
      end
      sleep_cfg  <= RST_SLEEP_CFG;
      irq_enable <= RST_IRQ;
    end else if (wr_hit) begin
      for (int i = 0; i < NUM_CTL; i++) begin
        if (req.address == OFS_EN_GROUP0 + 6'(4 * i)) begin
          en_group[i] <= NUM_REG'(merge_be({24'h00_0000, en_group[i]}, req.writedata,
                                           req.byteenable));
        end
      end
      for (int i = 0; i < NUM_GPO; i++) begin
        if (req.address == OFS_GPO_MASK0 + 6'(4 * i)) begin
          gpo_mask[i] <= NUM_REG'(merge_be({24'h00_0000, gpo_mask[i]}, req.writedata,
                                           req.byteenable));
        end
      end
      if (req.address == OFS_SLEEP_CFG) begin
        sleep_cfg <= merge_be(sleep_cfg, req.writedata, req.byteenable)
                     & 32'h00FF_FF03;
      end
      if (req.address == OFS_IRQ_ENABLE) begin
        irq_enable <= NUM_IRQ'(merge_be({27'h000_0000, irq_enable}, req.writedata,
                                        req.byteenable));
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_GPO; i++) begin
        gpo_cfg[i] <= rcp_gpo_cfg_t'(RST_GPO_CFG[2:0]);
      end
    end else if (wr_hit && req.address == OFS_GPO_CFG) begin
      for (int i = 0; i < NUM_GPO; i++) begin
        if (req.byteenable[(i * GPO_CFG_W) / 8]) begin
          gpo_cfg[i] <= rcp_gpo_cfg_t'(req.writedata[i*GPO_CFG_W +: 3]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Programming state detect

  logic [PROG_CNT_W-1:0] prog_cnt;

  // Short glitches on the high-voltage level must not start programming
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_cnt     <= '0;
      prog_state_o <= 1'b0;
    end else if (!prog_s) begin
      prog_cnt     <= '0;
      prog_state_o <= 1'b0;
    end else if (prog_cnt == PROG_CNT_W'(PROG_STAB_CY - 1)) begin
      prog_state_o <= 1'b1;
    end else begin
      prog_cnt <= prog_cnt + PROG_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Rail enable and sleep

  logic               slp_mode_a;
  logic               slp_mode_b;
  logic [NUM_CTL-1:0] ctl_as_enable;
  logic [NUM_REG-1:0] next_enable;
  logic [NUM_REG-1:0] next_sleep;

  assign slp_mode_a = sleep_cfg[SLP_MODE_A_BIT];
  assign slp_mode_b = sleep_cfg[SLP_MODE_B_BIT];

  always_comb begin
    ctl_as_enable    = ctl_s;
    ctl_as_enable[2] = ctl_s[2] & ~slp_mode_a;
    ctl_as_enable[5] = ctl_s[5] & ~slp_mode_b;
    // Input four carries the programming level, so it never switches rails then
    ctl_as_enable[3] = ctl_s[3] & ~prog_s & ~prog_state_o;
    next_enable = '0;
    for (int i = 0; i < NUM_CTL; i++) begin
      if (ctl_as_enable[i]) begin
        next_enable = next_enable | en_group[i];
      end
    end
    next_sleep = '0;
    if (slp_mode_a && !ctl_s[2]) begin
      next_sleep = next_sleep | sleep_cfg[SLP_GRP_A_LSB +: NUM_REG];
    end
    if (slp_mode_b && !ctl_s[5]) begin
      next_sleep = next_sleep | sleep_cfg[SLP_GRP_B_LSB +: NUM_REG];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      regulator_enable_o <= '0;
      regulator_sleep_o  <= '0;
    end else begin
      regulator_enable_o <= next_enable;
      regulator_sleep_o  <= next_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General outputs

  logic [NUM_GPO-1:0] gpo_val;

  always_comb begin
    for (int i = 0; i < NUM_GPO; i++) begin
      gpo_val[i] = gpo_cfg[i].src_user ? gpo_cfg[i].user_val
                                       : all_good(pg_s, gpo_mask[i]);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gen_out_o    <= '0;
      gen_out_oe_o <= '0;
    end else begin
      for (int i = 0; i < NUM_GPO; i++) begin
        // Output four ignores the push-pull choice
        if (gpo_cfg[i].pushpull && i != NUM_GPO - 1) begin
          gen_out_o[i]    <= gpo_val[i];
          gen_out_oe_o[i] <= 1'b1;
        end else begin
          gen_out_o[i]    <= 1'b0;
          gen_out_oe_o[i] <= ~gpo_val[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [NUM_IRQ-1:0] irq_status;
  logic [NUM_IRQ-1:0] irq_event;
  logic [NUM_IRQ-1:0] irq_clear;
  logic [NUM_REG-1:0] pg_prev;
  logic               prog_prev;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_prev   <= '0;
      prog_prev <= 1'b0;
    end else begin
      pg_prev   <= pg_s;
      prog_prev <= prog_state_o;
    end
  end

  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_EN_CHANGE] = |(next_enable ^ regulator_enable_o);
    irq_event[IRQ_SLP_ENTER] = |(next_sleep & ~regulator_sleep_o);
    irq_event[IRQ_SLP_EXIT]  = |(~next_sleep & regulator_sleep_o);
    irq_event[IRQ_PROG]      = prog_state_o & ~prog_prev;
    irq_event[IRQ_PG_FAULT]  = |(pg_prev & ~pg_s & regulator_enable_o);
    irq_clear = '0;
    if (wr_hit && req.address == OFS_IRQ_CLEAR && req.byteenable[0]) begin
      irq_clear = req.writedata[NUM_IRQ-1:0];
    end
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  // Open-drain: pulled low while any enabled event is pending
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_out_n_o    <= 1'b0;
      irq_out_n_oe_o <= 1'b0;
    end else begin
      irq_out_n_o    <= 1'b0;
      irq_out_n_oe_o <= |(((irq_status & ~irq_clear) | irq_event) & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the wait cycle

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NUM_CTL; i++) begin
      if (req.address == OFS_EN_GROUP0 + 6'(4 * i)) begin
        next_rdata = {24'h00_0000, en_group[i]};
      end
    end
    for (int i = 0; i < NUM_GPO; i++) begin
      if (req.address == OFS_GPO_MASK0 + 6'(4 * i)) begin
        next_rdata = {24'h00_0000, gpo_mask[i]};
      end
    end
    case (req.address)
      OFS_SLEEP_CFG: begin
        next_rdata = sleep_cfg;
      end
      OFS_GPO_CFG: begin
        for (int i = 0; i < NUM_GPO; i++) begin
          next_rdata[i*GPO_CFG_W +: 3] = gpo_cfg[i];
        end
      end
      OFS_STATUS: begin
        next_rdata[ST_EN_LSB +: NUM_REG]    = regulator_enable_o;
        next_rdata[ST_SLEEP_LSB +: NUM_REG] = regulator_sleep_o;
        next_rdata[ST_PG_LSB +: NUM_REG]    = pg_s;
        next_rdata[ST_PROG_BIT]             = prog_state_o;
      end
      OFS_IRQ_STATUS: begin
        next_rdata[NUM_IRQ-1:0] = irq_status;
      end
      OFS_IRQ_ENABLE: begin
        next_rdata[NUM_IRQ-1:0] = irq_enable;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (req.read && avs_waitrequest_o) begin
      avs_readdata_o <= next_rdata;
    end
  end

endmodule

// [bench/rcp_asserts.sv]
// Checker: bus handshake, drive kinds and pin timing of the rail control block
`timescale 1ns/1ps
module rcp_asserts
  import rcp_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic               avs_waitrequest_o,
  input  wire logic [NUM_CTL-1:0] rail_enable_in_i,
  input  wire logic               prog_level_i,
  input  wire logic [NUM_REG-1:0] regulator_enable_o,
  input  wire logic               prog_state_o,
  input  wire logic [NUM_GPO-1:0] gen_out_o,
  input  wire logic [NUM_GPO-1:0] gen_out_oe_o,
  input  wire logic               irq_out_n_o,
  input  wire logic               irq_out_n_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Raw high time of the level; a glitch must restart the count
  logic [PROG_CNT_W-1:0] hi_cnt;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt <= '0;
    end else if (!prog_level_i) begin
      hi_cnt <= '0;
    end else if (hi_cnt != '1) begin
      hi_cnt <= hi_cnt + 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_wait_one: assert property
    ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest not low one cycle after request");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_idle_stall: assert property
    (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest dropped without request");
  chk_out_four_od: assert property (!gen_out_o[3])
    else $error("output four driven high");
  chk_od_drive: assert property ((gen_out_o & ~gen_out_oe_o) == '0)
    else $error("output high while not driven");
  chk_irq_od: assert property (!irq_out_n_o)
    else $error("interrupt pin driven high");
  chk_prog_stable: assert property ($rose(prog_state_o) |-> hi_cnt >= PROG_STAB_CY)
    else $error("programming entered on short level");
  chk_prog_exit: assert property (!prog_level_i [*5] |-> !prog_state_o)
    else $error("programming state held after level low");
  chk_rails_off: assert property ((rail_enable_in_i == '0) [*4] |-> regulator_enable_o == '0)
    else $error("regulator on with all inputs low");
  cover property (avs_read_i && !avs_waitrequest_o);
  cover property ($rose(prog_state_o));
  cover property ($rose(irq_out_n_oe_o));
endmodule
bind rcp_top rcp_asserts u_rcp_asserts (.clk_i, .nrst_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .rail_enable_in_i, .prog_level_i, .regulator_enable_o, .prog_state_o,
  .gen_out_o, .gen_out_oe_o, .irq_out_n_o, .irq_out_n_oe_o);

// [bench/rcp_host_model.sv]
// Host model: drives the control pins and resolves the pulled-up output pins
`timescale 1ns/1ps
module rcp_host_model
  import rcp_pkg::*;
(
  input  wire logic [NUM_GPO-1:0] gen_out_o,
  input  wire logic [NUM_GPO-1:0] gen_out_oe_o,
  input  wire logic               irq_out_n_o,
  input  wire logic               irq_out_n_oe_o,
  output logic      [NUM_CTL-1:0] rail_enable_in_o,
  output logic                    prog_level_o,
  output logic      [NUM_REG-1:0] pgood_o,
  output logic      [NUM_GPO-1:0] gen_pin_o,
  output logic                    irq_pin_n_o
);
  initial begin
    rail_enable_in_o = '0;
    prog_level_o = 1'b0;
    pgood_o = '0;
  end
  // Undriven pins float to the pull-up level
  assign gen_pin_o   = (gen_out_oe_o & gen_out_o) | ~gen_out_oe_o;
  assign irq_pin_n_o = irq_out_n_oe_o ? irq_out_n_o : 1'b1;
  task automatic set_rails(input logic [NUM_CTL-1:0] v);
    rail_enable_in_o <= v;
  endtask
  task automatic set_pgood(input logic [NUM_REG-1:0] v);
    pgood_o <= v;
  endtask
  // Level is held steady, no pulses, for as long as programming lasts
  task automatic set_prog(input logic v);
    prog_level_o <= v;
  endtask
endmodule

// [bench/rcp_top_tb.sv]
// Testbench: bus, rail, output and interrupt scenarios of the rail control block
`timescale 1ns/1ps
module rcp_top_tb;
  import rcp_pkg::*;
  logic         clk_i = 1'b0;
  logic         nrst_i = 1'b0;
  logic [5:0]   avs_address_i = '0;
  logic         avs_read_i = 1'b0;
  logic         avs_write_i = 1'b0;
  logic [3:0]   avs_byteenable_i = 4'hF;
  logic [31:0]  avs_writedata_i = '0;
  logic [31:0]  avs_readdata_o;
  logic         avs_waitrequest_o;
  logic [5:0]   rail_enable_in_i;
  logic         prog_level_i;
  logic [7:0]   regulator_pgood_i;
  logic [7:0]   regulator_enable_o;
  logic [7:0]   regulator_sleep_o;
  logic         prog_state_o;
  logic [3:0]   gen_out_o;
  logic [3:0]   gen_out_oe_o;
  logic [3:0]   gen_pin;
  logic         irq_out_n_o;
  logic         irq_out_n_oe_o;
  logic         irq_pin_n;
  logic [31:0]  rdata;
  int           errors = 0;
  int           total_checks = 0;
  int           cycles = 0;
  rcp_top u_rcp_top (.clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .rail_enable_in_i, .prog_level_i, .regulator_pgood_i, .regulator_enable_o,
    .regulator_sleep_o, .prog_state_o, .gen_out_o, .gen_out_oe_o, .irq_out_n_o,
    .irq_out_n_oe_o);
  rcp_host_model u_host (.gen_out_o, .gen_out_oe_o, .irq_out_n_o, .irq_out_n_oe_o,
    .rail_enable_in_o(rail_enable_in_i), .prog_level_o(prog_level_i),
    .pgood_o(regulator_pgood_i), .gen_pin_o(gen_pin), .irq_pin_n_o(irq_pin_n));
  always #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the longest path, the programming wait
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One idle edge after each access so strobes never change twice in a step
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
  endtask
  task automatic rail(input logic [5:0] p, input logic [15:0] exp);
    u_host.set_rails(p);
    cyc(4);
    chk({regulator_sleep_o, regulator_enable_o}, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({avs_waitrequest_o, regulator_enable_o, regulator_sleep_o, prog_state_o,
         gen_out_oe_o, irq_out_n_oe_o}, 32'h0040_0000);
    for (int a = 0; a < 64; a += 4) begin
      rd_chk(a[5:0], 32'h0000_0000);
    end
  endtask
  task automatic t_rails;
    bus(1'b1, OFS_EN_GROUP0, 32'h0000_0005);
    bus(1'b1, 6'h04, 32'h0000_0030);
    rd_chk(6'h04, 32'h0000_0030);
    rail(6'h01, 16'h0005);
    rail(6'h03, 16'h0035);
    rail(6'h02, 16'h0030);
    rail(6'h00, 16'h0000);
  endtask
  task automatic t_sleep(input logic [5:0] ofs, input logic [31:0] cfg, input logic [5:0] lo);
    bus(1'b1, ofs, 32'h0000_00C0);
    bus(1'b1, OFS_SLEEP_CFG, cfg);
    rail(6'h3F, 16'h0035);
    rail(lo, 16'h0C35);
    rail(6'h3F, 16'h0035);
    bus(1'b1, OFS_SLEEP_CFG, 32'h0000_0000);
    rail(6'h3F, 16'h00F5);
    rail(6'h00, 16'h0000);
    bus(1'b1, ofs, 32'h0000_0000);
  endtask
  task automatic t_prog;
    bus(1'b1, 6'h0C, 32'h0000_0080);
    u_host.set_rails(6'h08);
    u_host.set_prog(1'b1);
    cyc(10);
    chk({prog_state_o, regulator_enable_o}, 32'h0000_0000);
    cyc(2000);
    chk({prog_state_o, regulator_enable_o}, 32'h0000_0100);
    rd_chk(OFS_STATUS, 32'h0100_0000);
    u_host.set_prog(1'b0);
    cyc(5);
    chk({prog_state_o, regulator_enable_o}, 32'h0000_0080);
    u_host.set_rails(6'h00);
    bus(1'b1, 6'h0C, 32'h0000_0000);
  endtask
  task automatic t_gpo;
    bus(1'b1, OFS_GPO_MASK0, 32'h0000_0003);
    bus(1'b1, OFS_GPO_MASK3, 32'h0000_0003);
    bus(1'b1, OFS_GPO_CFG, 32'h0000_1001);
    u_host.set_pgood(8'h03);
    cyc(4);
    chk({gen_out_oe_o, gen_pin}, 32'h0000_001F);
    u_host.set_pgood(8'h01);
    cyc(4);
    chk({gen_out_oe_o, gen_pin}, 32'h0000_0096);
    rd_chk(OFS_STATUS, 32'h0001_0000);
    bus(1'b1, OFS_GPO_CFG, 32'h0000_6270);
    cyc(2);
    chk({gen_out_oe_o, gen_pin}, 32'h0000_007A);
    // Only lane one: outputs three and four lose their settings
    avs_byteenable_i <= 4'h2;
    bus(1'b1, OFS_GPO_CFG, 32'h0000_0000);
    avs_byteenable_i <= 4'hF;
    rd_chk(OFS_GPO_CFG, 32'h0000_0070);
  endtask
  task automatic t_irq;
    rd_chk(OFS_IRQ_STATUS, 32'h0000_000F);
    chk(irq_pin_n, 1'b1);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0001);
    cyc(1);
    chk(irq_pin_n, 1'b0);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h0000_001F);
    cyc(1);
    chk(irq_pin_n, 1'b1);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
    rail(6'h01, 16'h0005);
    chk(irq_pin_n, 1'b1);
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0000);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0001);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0001);
    cyc(1);
    chk(irq_pin_n, 1'b0);
    u_host.set_pgood(8'h00);
    cyc(4);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0011);
  endtask
  initial begin
    cyc(5);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_rails();
    t_sleep(6'h08, 32'h0000_0C01, 6'h3B);
    t_sleep(OFS_EN_GROUP5, 32'h000C_0002, 6'h1F);
    t_prog();
    t_gpo();
    t_irq();
    give_verdict();
  end
endmodule
